// ===== core/phmc_port.sv
/*
 * One PHY port: power-up strap capture, mode resolution by forcing,
 * negotiation or parallel detection, MII clocks and data paths, line
 * transmit codes, crossover control and a Wishbone register slave.
 * Assumes a 50 MHz reference clock; line-side receive nibbles come from
 * a decoder on the same clock, line status flags and pins are async.
 */
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module phmc_port
    import phmc_pkg::*;
#(
    parameter int XOVER_SLOT_CYC = 2000
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rate_select_port0_i,
    input wire logic fd_select_port0_i,
    input wire logic media_select_port0_i,
    input wire logic sleep_pin_port0_i,
    input wire logic negotiate_enable_port0_i,
    input wire logic line_flp_i,
    input wire logic line_nlp_i,
    input wire logic line_idle_i,
    input wire logic line_energy_i,
    input wire logic line_partner_100_i,
    input wire logic line_partner_fd_i,
    input wire logic [3:0] line_rxd_i,
    input wire logic line_rx_act_i,
    input wire logic line_rx_bad_i,
    input wire logic [3:0] txd_i,
    input wire logic tx_en_i,
    input wire logic tx_er_i,
    output logic tx_clk_o,
    output logic rx_clk_o,
    output logic [3:0] rxd_o,
    output logic rx_dv_o,
    output logic rx_er_o,
    output logic crs_o,
    output logic col_o,
    output logic [3:0] line_txd_o,
    output logic [2:0] line_tx_code_o,
    output logic line_crossed_o,
    output logic link_up_o,
    output logic speed_100_o,
    output logic full_duplex_o,
    output logic fibre_o,
    output logic sleeping_o
);
    generate
        if (XOVER_SLOT_CYC < 2 || XOVER_SLOT_CYC > 65535) begin : g_chk
            $error("XOVER_SLOT_CYC out of range");
        end
    endgenerate

    // Synchronised pins and line status flags
    wire logic [4:0] pins_s;
    wire logic [5:0] stat_s;
    phmc_sync #(.W(5)) u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i({negotiate_enable_port0_i, sleep_pin_port0_i,
                media_select_port0_i, fd_select_port0_i,
                rate_select_port0_i}),
        .q_o(pins_s)
    );
    phmc_sync #(.W(6)) u_stat_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i({line_partner_fd_i, line_partner_100_i, line_energy_i,
                line_idle_i, line_nlp_i, line_flp_i}),
        .q_o(stat_s)
    );
    wire logic sleep_s = pins_s[3];
    wire logic flp_s = stat_s[0];
    wire logic nlp_s = stat_s[1];
    wire logic idle_s = stat_s[2];
    wire logic energy_s = stat_s[3];
    wire logic p100_s = stat_s[4];
    wire logic pfd_s = stat_s[5];

    // State and captured settings
    phmc_state_t st_q;
    logic [2:0] strap_cnt_q;
    logic rate_q, fd_q, tp_q, neg_q;
    logic spd_q, full_q, par_q, fibre_q;
    logic fibre_reg_q;
    logic [1:0] xover_q;

    // Fibre excludes negotiation; forced copper ports take their pins
    wire logic fibre_w = !tp_q || fibre_reg_q;
    wire logic forced_w = !neg_q || fibre_w;
    wire logic linked_w = (st_q == PHMC_LINK);
    wire logic strap_rdy_w = (strap_cnt_q == 3'(STRAP_WAIT_CYC - 1));

    // Mode resolution state machine
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_q <= PHMC_STRAP;
            strap_cnt_q <= 3'h0;
            {rate_q, fd_q, tp_q, neg_q} <= 4'h0;
            {spd_q, full_q, par_q, fibre_q} <= 4'h0;
        end else if (ce_i) begin
            unique case (st_q)
                PHMC_STRAP: begin
                    strap_cnt_q <= strap_cnt_q + 3'h1;
                    if (strap_rdy_w) begin
                        rate_q <= pins_s[0];
                        fd_q <= pins_s[1];
                        tp_q <= pins_s[2];
                        neg_q <= pins_s[4];
                        st_q <= PHMC_LISTEN;
                    end
                end
                PHMC_SLEEP: begin
                    if (!sleep_s) begin
                        st_q <= PHMC_LISTEN;
                    end
                end
                PHMC_LISTEN: begin
                    fibre_q <= fibre_w;
                    if (sleep_s) begin
                        st_q <= PHMC_SLEEP;
                    end else if (forced_w) begin
                        if (energy_s) begin
                            spd_q <= rate_q || fibre_w;
                            full_q <= fd_q;
                            par_q <= 1'b0;
                            st_q <= PHMC_LINK;
                        end
                    end else if (flp_s) begin
                        spd_q <= rate_q && p100_s;
                        full_q <= fd_q && pfd_s;
                        par_q <= 1'b0;
                        st_q <= PHMC_LINK;
                    end else if (nlp_s || idle_s) begin
                        spd_q <= !nlp_s;
                        full_q <= 1'b0;
                        par_q <= 1'b1;
                        st_q <= PHMC_LINK;
                    end
                end
                PHMC_LINK: begin
                    if (sleep_s) begin
                        st_q <= PHMC_SLEEP;
                    end else if (!energy_s) begin
                        st_q <= PHMC_LISTEN;
                    end
                end
            endcase
        end
    end

    // MII clock source, shared by transmit and receive
    wire logic mii_clk_w, rise_w, fall_w;
    phmc_clkgen u_clkgen (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .fast_i(spd_q),
        .mii_clk_o(mii_clk_w),
        .rise_o(rise_w),
        .fall_o(fall_w)
    );
    assign tx_clk_o = mii_clk_w;
    assign rx_clk_o = mii_clk_w;

    // Transmit capture on the clock's rising edge
    logic [3:0] txd_q;
    logic tx_en_q, tx_er_q;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            txd_q <= 4'h0;
            tx_en_q <= 1'b0;
            tx_er_q <= 1'b0;
        end else if (rise_w) begin
            txd_q <= txd_i;
            tx_en_q <= tx_en_i;
            tx_er_q <= tx_er_i;
        end
    end

    // Line code selection; sleeping port goes silent
    logic [2:0] code_q;
    logic [3:0] ltxd_q;
    wire logic [2:0] quiet_w = spd_q ? CODE_IDLE : CODE_PULSE;
    wire logic [2:0] code_d =
        (st_q == PHMC_LISTEN && !forced_w) ? CODE_BURST :
        !linked_w ? CODE_OFF :
        tx_er_q ? CODE_HALT :
        tx_en_q ? CODE_DATA : quiet_w;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            code_q <= CODE_OFF;
            ltxd_q <= 4'h0;
        end else if (ce_i) begin
            code_q <= code_d;
            ltxd_q <= (code_d == CODE_DATA) ? txd_q : 4'h0;
        end
    end

    // Receive path, updated on the falling edge for MAC rising sampling
    logic [3:0] rxd_q, prev_q;
    logic dv_q, er_q, act_d_q;
    // At 10 Mbps the stream runs one nibble late so SFD can be spotted
    wire logic sfd_w = (prev_q == NIB_SFD_LO) && (line_rxd_i == NIB_SFD_HI);
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rxd_q <= 4'h0;
            prev_q <= 4'h0;
            dv_q <= 1'b0;
            er_q <= 1'b0;
            act_d_q <= 1'b0;
        end else if (fall_w) begin
            prev_q <= line_rxd_i;
            act_d_q <= line_rx_act_i;
            if (!linked_w) begin
                dv_q <= 1'b0;
                er_q <= 1'b0;
                rxd_q <= 4'h0;
            end else if (spd_q) begin
                dv_q <= line_rx_act_i;
                er_q <= line_rx_act_i && line_rx_bad_i;
                rxd_q <= line_rx_bad_i ? NIB_BAD : line_rxd_i;
            end else begin
                er_q <= 1'b0;
                rxd_q <= prev_q;
                if (line_rx_act_i && act_d_q && sfd_w) begin
                    dv_q <= 1'b1;
                end else if (!act_d_q) begin
                    dv_q <= 1'b0;
                end
            end
        end
    end
    assign rxd_o = rxd_q;
    assign rx_dv_o = dv_q;
    assign rx_er_o = er_q;

    // Carrier and collision; carrier on transmit only in half duplex
    logic crs_q, col_q, link_q, sleep_q;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            crs_q <= 1'b0;
            col_q <= 1'b0;
            link_q <= 1'b0;
            sleep_q <= 1'b0;
        end else if (ce_i) begin
            crs_q <= linked_w && (line_rx_act_i || (tx_en_q && !full_q));
            col_q <= linked_w && !full_q && tx_en_q && line_rx_act_i;
            link_q <= linked_w; // Link and sleep pins lag state by one cycle
            sleep_q <= (st_q == PHMC_SLEEP);
        end
    end
    assign crs_o = crs_q;
    assign col_o = col_q;

    // Crossover: automatic mode hunts by toggling while link is down
    logic [15:0] slot_q;
    logic crossed_q;
    wire logic slot_end_w = (slot_q == 16'(XOVER_SLOT_CYC - 1));
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            slot_q <= 16'h0000;
            crossed_q <= 1'b0;
        end else if (ce_i) begin
            slot_q <= slot_end_w ? 16'h0000 : slot_q + 16'h0001;
            if (xover_q == XOVER_MDI) begin
                crossed_q <= 1'b0;
            end else if (xover_q == XOVER_CROSSOVER_FUNCTION) begin
                crossed_q <= 1'b1;
            end else if (slot_end_w && !linked_w) begin
                crossed_q <= ~crossed_q;
            end
        end
    end
    assign line_crossed_o = crossed_q;

    // Wishbone slave: ack one cycle after request, write on ack edge
    logic ack_q;
    logic [31:0] rdat_q;
    wire logic req_w = wb_cyc_i && wb_stb_i;
    wire logic [5:0] idx_w = wb_adr_i[7:2];
    wire logic wr_w = req_w && wb_we_i && ack_q;
    wire logic [7:0] stat_w = {!forced_w, crossed_q,
                               st_q == PHMC_SLEEP, par_q, fibre_q,
                               full_q, spd_q, linked_w};
    wire logic [31:0] rmux_w =
        (idx_w == IDX_PCFG) ? {31'h0, fibre_reg_q} :
        (idx_w == IDX_PSTAT) ? {24'h0, stat_w} :
        (idx_w == IDX_XOVER) ? {22'h0, xover_q, 8'h00} : 32'h0;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            fibre_reg_q <= PCFG_FIBRE_RST;
            xover_q <= XOVER_RST;
        end else if (ce_i) begin
            ack_q <= req_w && !ack_q;
            if (req_w && !ack_q) begin
                rdat_q <= rmux_w;
            end
            if (wr_w && idx_w == IDX_PCFG && wb_sel_i[0]) begin
                fibre_reg_q <= wb_dat_i[FIBRE_BIT];
            end
            if (wr_w && idx_w == IDX_XOVER && wb_sel_i[1]) begin
                xover_q <= wb_dat_i[XOVER_LSB+1:XOVER_LSB];
            end
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Line transmit and status pins
    assign line_txd_o = ltxd_q;
    assign line_tx_code_o = code_q;
    assign link_up_o = link_q;
    assign speed_100_o = spd_q;
    assign full_duplex_o = full_q;
    assign fibre_o = fibre_q;
    assign sleeping_o = sleep_q;

    property p_sleep;
        @(posedge ref_clk_i) disable iff (rst_i)
        ce_i && sleep_s && st_q != PHMC_STRAP |=> st_q == PHMC_SLEEP;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep pin did not power down the port");

    property p_parallel;
        @(posedge ref_clk_i) disable iff (rst_i)
        ce_i && st_q == PHMC_LISTEN && !sleep_s && !forced_w && !flp_s
        && nlp_s |=> linked_w && !full_q && !spd_q && par_q;
    endproperty
    a_parallel: assert property (p_parallel)
        else $error("parallel detect not 10 Mbps half duplex");

    property p_fibre;
        @(posedge ref_clk_i) disable iff (rst_i)
        linked_w && fibre_q |-> spd_q && !par_q;
    endproperty
    a_fibre: assert property (p_fibre)
        else $error("fibre link not forced 100 Mbps");

    property p_halt;
        @(posedge ref_clk_i) disable iff (rst_i)
        ce_i && linked_w && tx_er_q |=> code_q == CODE_HALT;
    endproperty
    a_halt: assert property (p_halt)
        else $error("transmit error did not send halt");

    property p_quiet;
        @(posedge ref_clk_i) disable iff (rst_i)
        ce_i && linked_w && !tx_en_q && !tx_er_q
        |=> code_q == (spd_q ? CODE_IDLE : CODE_PULSE);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("idle line code wrong for rate");

    property p_bad;
        @(posedge ref_clk_i) disable iff (rst_i)
        fall_w && linked_w && spd_q && line_rx_act_i && line_rx_bad_i
        |=> rx_er_o && rxd_o == NIB_BAD && rx_dv_o;
    endproperty
    a_bad: assert property (p_bad)
        else $error("invalid symbol not flagged");

    property p_sfd;
        @(posedge ref_clk_i) disable iff (rst_i)
        fall_w && linked_w && !spd_q && line_rx_act_i && act_d_q && sfd_w
        |=> rx_dv_o && rxd_o == NIB_SFD_LO;
    endproperty
    a_sfd: assert property (p_sfd)
        else $error("10 Mbps valid not raised at SFD");

    property p_xover_rst;
        @(posedge ref_clk_i) disable iff (rst_i)
        $past(rst_i) |-> xover_q == XOVER_AUTO;
    endproperty
    a_xover_rst: assert property (p_xover_rst)
        else $error("crossover not automatic after reset");

    property p_txcap;
        @(posedge ref_clk_i) disable iff (rst_i)
        rise_w |=> tx_en_q == $past(tx_en_i) && txd_q == $past(txd_i);
    endproperty
    a_txcap: assert property (p_txcap)
        else $error("transmit inputs not captured on rising edge");
endmodule // phmc_port
`default_nettype wire

// ===== core/phmc_pkg.sv
/*
 * Shared constants for the PHY port mode and MII block: clock rates,
 * register indices, field positions, reset values and line codes.
 * Assumes a 50 MHz reference clock feeding every module that imports it.
 */
package phmc_pkg;
    // Reference and MII nibble clock rates
    localparam int REF_KHZ = 50000;
    localparam int MII_FAST_KHZ = 25000;
    localparam int MII_SLOW_KHZ = 2500;
    localparam int HALF_FAST_CYC = REF_KHZ / (2 * MII_FAST_KHZ);
    localparam int HALF_SLOW_CYC = REF_KHZ / (2 * MII_SLOW_KHZ);
    // Settle time before the power-up straps are caught
    localparam int STRAP_WAIT_CYC = 6;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_PCFG = 6'h10;
    localparam logic [5:0] IDX_PSTAT = 6'h11;
    localparam logic [5:0] IDX_XOVER = 6'h1B;
    localparam int FIBRE_BIT = 0;
    localparam int XOVER_LSB = 8;
    localparam logic PCFG_FIBRE_RST = 1'b0;
    localparam logic [1:0] XOVER_MDI = 2'h0;
    localparam logic [1:0] XOVER_CROSSOVER_FUNCTION = 2'h1;
    localparam logic [1:0] XOVER_AUTO = 2'h2;
    localparam logic [1:0] XOVER_RST = XOVER_AUTO;
    // Status register bit positions
    localparam int ST_LINK = 0;
    localparam int ST_SPEED = 1;
    localparam int ST_FULL = 2;
    localparam int ST_FIBRE = 3;
    localparam int ST_PARALLEL = 4;
    localparam int ST_SLEEP = 5;
    localparam int ST_CROSSED = 6;
    localparam int ST_NEG = 7;
    // Receive nibble values
    localparam logic [3:0] NIB_SFD_LO = 4'h5;
    localparam logic [3:0] NIB_SFD_HI = 4'hD;
    localparam logic [3:0] NIB_BAD = 4'hE;
    // Line transmit codes
    localparam logic [2:0] CODE_OFF = 3'h0;
    localparam logic [2:0] CODE_PULSE = 3'h1;
    localparam logic [2:0] CODE_IDLE = 3'h2;
    localparam logic [2:0] CODE_BURST = 3'h3;
    localparam logic [2:0] CODE_DATA = 3'h4;
    localparam logic [2:0] CODE_HALT = 3'h5;
    typedef enum logic [1:0] {
        PHMC_STRAP,
        PHMC_SLEEP,
        PHMC_LISTEN,
        PHMC_LINK
    } phmc_state_t;
endpackage

// ===== core/phmc_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes inputs are asynchronous to ref_clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
module phmc_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;
    // First stage feeds only the second
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else if (ce_i) begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= (s2_q & s3_q) | (out_q & (s2_q ^ s3_q)) |
                     (out_q & s2_q & s3_q);
        end
    end
    assign q_o = out_q;
endmodule // phmc_sync
`default_nettype wire

// ===== core/phmc_clkgen.sv
/*
 * MII nibble clock divider: 25 MHz or 2.5 MHz from the reference clock,
 * with edge strobes for the port logic. Assumes a 50 MHz reference.
 */
`timescale 1ns/100ps
`default_nettype none
module phmc_clkgen
    import phmc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic fast_i,
    output logic mii_clk_o,
    output logic rise_o,
    output logic fall_o
);
    localparam logic [4:0] HALF_F = 5'(HALF_FAST_CYC - 1);
    localparam logic [4:0] HALF_S = 5'(HALF_SLOW_CYC - 1);
    logic [4:0] cnt_q;
    logic clk_q;
    logic fast_q;
    wire logic [4:0] top_w = fast_i ? HALF_F : HALF_S;
    wire logic tick_w = ce_i && (cnt_q >= top_w);
    // Counter restarts on a rate change so no short half-period leaks out
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_q <= 5'h00;
            clk_q <= 1'b0;
            fast_q <= 1'b0;
        end else if (ce_i) begin
            fast_q <= fast_i;
            cnt_q <= (tick_w || fast_q != fast_i) ? 5'h00 : cnt_q + 5'h01;
            if (tick_w) begin
                clk_q <= ~clk_q;
            end
        end
    end
    assign mii_clk_o = clk_q;
    assign rise_o = tick_w && !clk_q;
    assign fall_o = tick_w && clk_q;

    property p_clk_fast;
        @(posedge ref_clk_i) disable iff (rst_i)
        ce_i && fast_i && fast_q && clk_q |=> !clk_q;
    endproperty
    a_clk_fast: assert property (p_clk_fast)
        else $error("fast MII clock did not toggle");
endmodule // phmc_clkgen
`default_nettype wire

// ===== dv/phmc_mac_model.sv
/* MAC side of the nibble interface, driving the transmit lines.
   Assumes tx_clk_i is the transmit clock sourced by the port. */
`timescale 1ns/100ps
`default_nettype none
module phmc_mac_model (
    input wire logic tx_clk_i,
    input wire logic send_i,
    input wire logic err_i,
    output logic [3:0] txd_o,
    output logic tx_en_o,
    output logic tx_er_o
);
    // Quiet lines at time zero
    initial begin
        txd_o = 4'h0;
        tx_en_o = 1'b0;
        tx_er_o = 1'b0;
    end
    // Launch after the port's rising edge, never on it
    // Enable held for the whole frame; idle data keeps toggling
    always @(posedge tx_clk_i) begin
        tx_en_o <= send_i;
        tx_er_o <= err_i;
        txd_o <= send_i ? 4'h5 : ~txd_o;
    end
endmodule // phmc_mac_model
`default_nettype wire

// ===== dv/tb_top.sv
/* Bench for one port: strap rows, registers, receive and transmit paths.
   Assumes the package, the design and the MAC model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import phmc_pkg::*;
    logic ref_clk_i = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, send = 0;
    logic err = 0, slp = 0, energy = 0, act = 0, bad = 0, tx_clk, dv, er;
    logic link, spd, full, fib, sleeping, en, ter;
    logic [8:0] pins = 9'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, r;
    logic [3:0] lrxd = 4'h0, rxd, txd;
    logic [2:0] code;
    logic ce = 1, crs, col, xo, rxc;
    logic [3:0] ltx;
    int n_mismatch = 0, check_count = 0, cycles = 0, n, m;
    // Pins: rate fd media neg flp nlp idle p100 pfd; then speed full fibre
    logic [11:0] rows [7] = '{12'b111000000_110, 12'b001000000_000,
        12'b010000000_111, 12'b111110011_110, 12'b111101000_000,
        12'b111100100_100, 12'b011110011_010};
    always #10 ref_clk_i = ~ref_clk_i;
    phmc_port phmc_port_i (.ref_clk_i(ref_clk_i), .rst_i(rst), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rate_select_port0_i(pins[8]), .fd_select_port0_i(pins[7]),
        .media_select_port0_i(pins[6]), .sleep_pin_port0_i(slp),
        .negotiate_enable_port0_i(pins[5]), .line_flp_i(pins[4]),
        .line_nlp_i(pins[3]), .line_idle_i(pins[2]),
        .line_energy_i(energy), .line_partner_100_i(pins[1]),
        .line_partner_fd_i(pins[0]), .line_rxd_i(lrxd),
        .line_rx_act_i(act), .line_rx_bad_i(bad), .txd_i(txd),
        .tx_en_i(en), .tx_er_i(ter), .tx_clk_o(tx_clk), .rx_clk_o(rxc),
        .rxd_o(rxd), .rx_dv_o(dv), .rx_er_o(er), .crs_o(crs), .col_o(col),
        .line_txd_o(ltx), .line_tx_code_o(code), .line_crossed_o(xo),
        .link_up_o(link), .speed_100_o(spd), .full_duplex_o(full),
        .fibre_o(fib), .sleeping_o(sleeping));
    phmc_mac_model phmc_mac_model_i (.tx_clk_i(tx_clk), .send_i(send),
        .err_i(err), .txd_o(txd), .tx_en_o(en), .tx_er_o(ter));
    // One comparison, counted
    task automatic chk(input logic [31:0] s, input logic [31:0] e,
        input string w);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", w, e, s);
        end
    endtask
    // Classic single cycle; held until ack is seen at an edge
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge ref_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge ref_clk_i); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // Straps set before reset so they are steady at capture time
    task automatic bring_up(input int k);
        pins <= rows[k][11:3];
        energy <= 1'b0;
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        rst <= 1'b0;
        repeat (12) @(posedge ref_clk_i);
        energy <= 1'b1;
        repeat (8) @(posedge ref_clk_i); // Synced energy settles first
        for (int i = 0; i < 300 && link !== 1'b1; i++) @(posedge ref_clk_i);
        @(posedge ref_clk_i);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard, well above the expected run length
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        for (int k = 0; k < 7; k++) begin
            bring_up(k);
            chk(link, 1'b1, "link");
            chk(spd, rows[k][2], "speed");
            chk(full, rows[k][1], "duplex");
            chk(fib, rows[k][0], "fibre");
            chk(code, rows[k][2] ? CODE_IDLE : CODE_PULSE, "idle");
            @(posedge tx_clk);
            n = 0;
            // Counted on falling edges, away from the clock's launch edge
            while (tx_clk === 1'b1) begin
                @(negedge ref_clk_i);
                n++;
            end
            chk(rxc, tx_clk, "rx clock");
            m = rows[k][2] ? HALF_FAST_CYC : HALF_SLOW_CYC;
            chk(n - 1, m, "half");
            $display("row %0d done", k);
        end
        // Registers after reset, write back, unmapped place
        bring_up(0);
        wb(1'b0, 8'h6C, 32'h0);
        chk(r[9:8], XOVER_AUTO, "xover reset");
        wb(1'b1, 8'h6C, 32'h0);
        wb(1'b0, 8'h6C, 32'h0);
        chk(r[9:8], XOVER_MDI, "xover write");
        wb(1'b1, 8'h6C, 32'h100);
        repeat (2) @(posedge ref_clk_i);
        chk(xo, 1'b1, "crossed");
        wb(1'b1, 8'h40, 32'h1);
        wb(1'b0, 8'h40, 32'h0);
        chk(r[0], 1'b1, "fibre bit");
        wb(1'b0, 8'h44, 32'h0);
        chk(r[7:0], 8'h47, "status");
        wb(1'b0, 8'h00, 32'h0);
        chk(r, 32'h0, "unmapped");
        $display("register test done");
        // 100 Mbps receive: valid from first nibble, bad symbol code
        act <= 1'b1;
        lrxd <= 4'hA;
        for (int i = 0; i < 20 && dv !== 1'b1; i++) @(posedge ref_clk_i);
        chk(rxd, 4'hA, "rx nibble");
        chk({crs, col}, 2'b10, "carrier");
        bad <= 1'b1;
        for (int i = 0; i < 20 && er !== 1'b1; i++) @(posedge ref_clk_i);
        chk({dv, rxd}, {1'b1, NIB_BAD}, "bad symbol");
        act <= 1'b0;
        bad <= 1'b0;
        // Transmit capture, then halt on error from the MAC
        send <= 1'b1;
        for (int i = 0; i < 20 && code !== CODE_DATA; i++)
            @(posedge ref_clk_i);
        chk({code, ltx}, {CODE_DATA, 4'h5}, "tx data");
        err <= 1'b1;
        for (int i = 0; i < 20 && code !== CODE_HALT; i++)
            @(posedge ref_clk_i);
        chk(code, CODE_HALT, "tx halt");
        send <= 1'b0;
        err <= 1'b0;
        $display("data path test done");
        // 10 Mbps: preamble hidden, valid opens on the delimiter
        bring_up(1);
        act <= 1'b1;
        send <= 1'b1;
        lrxd <= NIB_SFD_LO;
        repeat (60) @(posedge ref_clk_i);
        chk(dv, 1'b0, "preamble");
        chk({crs, col}, 2'b11, "collision");
        send <= 1'b0;
        lrxd <= NIB_SFD_HI;
        for (int i = 0; i < 90 && dv !== 1'b1; i++) @(posedge ref_clk_i);
        chk({dv, rxd}, {1'b1, NIB_SFD_LO}, "delimiter");
        act <= 1'b0;
        // Power-down pin
        slp <= 1'b1;
        for (int i = 0; i < 20 && sleeping !== 1'b1; i++)
            @(posedge ref_clk_i);
        chk(sleeping, 1'b1, "sleep");
        // Clock enable low must hold the MII clock still
        ce <= 1'b0;
        @(posedge ref_clk_i);
        n = tx_clk;
        repeat (30) @(posedge ref_clk_i);
        chk(tx_clk, n[0], "freeze");
        ce <= 1'b1;
        $display("10 Mbps, sleep and freeze test done");
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
